// File: shared/dphp_regs.svh
/*
 * Constants of the demultiplexed parallel host port: widths, memory depth,
 * synchroniser bit positions, reset values and the strap settling count.
 * Assumes it is included by bare name and sees no other definitions.
 */
`ifndef DPHP_REGS_SVH
`define DPHP_REGS_SVH

`define DPHP_DATA_W        16
`define DPHP_ADDR_W        15
`define DPHP_WADDR_W       14
`define DPHP_MEM_DEPTH     16384
`define DPHP_CTL_W         8
`define DPHP_STRAP_W       3

`define DPHP_C_CS          0
`define DPHP_C_RD          1
`define DPHP_C_WR          2
`define DPHP_C_WRL         3
`define DPHP_C_WRH         4
`define DPHP_C_EN          5
`define DPHP_C_RNW         6
`define DPHP_C_L0          7
`define DPHP_C_L1          8

`define DPHP_STRAP_SETTLE  2'h3
`define DPHP_OE_OFF        16'hFFFF
`define DPHP_OE_LOW_BYTE   16'hFF00
`define DPHP_OE_WORD       16'h0000
`define DPHP_DOUT_RST      16'h0000
`define DPHP_LANE_NONE     2'h0
`define DPHP_LANE_LO       2'h1
`define DPHP_LANE_HI       2'h2
`define DPHP_LANE_BOTH     2'h3

`endif

// File: shared/dphp_pkg.sv
/*
 * Types of the demultiplexed parallel host port: port mode and write
 * sequencer state, both one-hot.
 * Assumes nothing of its surroundings.
 */
package dphp_pkg;

	typedef enum logic [4:0] {
		mode_none  = 5'b00001,
		mode_sep8  = 5'b00010,
		mode_en8   = 5'b00100,
		mode_sep16 = 5'b01000,
		mode_sel16 = 5'b10000
	} dphp_mode_t;

	typedef enum logic [1:0] {
		wst_idle  = 2'b01,
		wst_pulse = 2'b10
	} dphp_wstate_t;

endpackage : dphp_pkg

// File: logic/dphp_mem.sv
/*
 * Word memory behind the host port, 16-bit words with two byte lanes.
 * Assumes one clock; the read data come out of a register one edge after
 * the read address is presented.
 */
`timescale 1ns/1ps
`include "dphp_regs.svh"

module dphp_mem (
	input  wire logic                       core_clk_i,
	input  wire logic                       rstn_i,
	input  wire logic                       we_i,
	input  wire logic [1:0]                 be_i,
	input  wire logic [`DPHP_WADDR_W-1:0]   waddr_i,
	input  wire logic [`DPHP_DATA_W-1:0]    wdata_i,
	input  wire logic [`DPHP_WADDR_W-1:0]   raddr_i,
	output logic      [`DPHP_DATA_W-1:0]    rdata_o
);

	logic [`DPHP_DATA_W-1:0] mem_q [`DPHP_MEM_DEPTH];
	logic [`DPHP_DATA_W-1:0] rdata_q;

	// byte lanes written apart so half a word survives a lane write
	always_ff @(posedge core_clk_i) begin
		if (we_i && be_i[0]) begin
			mem_q[waddr_i][7:0] <= wdata_i[7:0];
		end
		if (we_i && be_i[1]) begin
			mem_q[waddr_i][15:8] <= wdata_i[15:8];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			rdata_q <= `DPHP_DOUT_RST;
		end else begin
			rdata_q <= mem_q[raddr_i];
		end
	end

	assign rdata_o = rdata_q;

endmodule : dphp_mem

// File: logic/dphp_port.sv
/*
 * Slave side of a demultiplexed asynchronous parallel host port with four
 * strap-selected modes (two 8-bit, two 16-bit), backed by a word memory.
 * Assumes straps are static, all pins asynchronous to core_clk_i, and the
 * host holds address and data stable while a write strobe is high.
 */
// Function
// - straps 2,3,4 low: 8-bit mode with separate read and write strobes
// - straps 2,3 low, 4 high: 8-bit mode with read-not-write and enable
// - strap 2 high, 3,4 low: 16-bit mode, read plus low/high writes
// - straps 2,4 high, 3 low: 16-bit mode, read-not-write, lane selects
// - 8-bit strobe mode: data pins released while select or read low
// - read drives bus after strobe rises, releases after strobe falls
// - enable mode: direction high reads, low writes, only during enable
// - enable mode: bus released when select, enable or direction low
// - 16-bit modes always return the full word on a read
// - 16-bit strobe mode: low, high or both strobes write those bytes
// - 16-bit strobe mode: all 16 pins released when select or read low
// - lane-select mode: any lane with direction high reads, low writes
// - lane-select mode: bus released on no select, write, or no lanes
// - lane-select mode: drive on any lane, release only when both low
// - lane-select mode write: lane 0 low byte, lane 1 high, both word
// - 16-bit modes: address bits 13:0 pick the word (bit 14 ignored), lanes write halves
// - pins unused by the mode stay released whatever the select
`timescale 1ns/1ps
`include "dphp_regs.svh"

module dphp_port (
	input  wire logic                      core_clk_i,
	input  wire logic                      rstn_i,
	input  wire logic                      mode_strap_2_i,
	input  wire logic                      mode_strap_3_i,
	input  wire logic                      mode_strap_4_i,
	input  wire logic                      cs_i,
	input  wire logic                      rd_i,
	input  wire logic                      wr_i,
	input  wire logic                      write_low_strobe_i,
	input  wire logic                      write_high_strobe_i,
	input  wire logic                      en_i,
	input  wire logic                      rnw_i,
	input  wire logic                      lane0_select_i,
	input  wire logic                      lane1_select_i,
	input  wire logic [`DPHP_ADDR_W-1:0]   addr_i,
	input  wire logic [`DPHP_DATA_W-1:0]   ad_i,
	output logic      [`DPHP_DATA_W-1:0]   ad_o,
	output logic      [`DPHP_DATA_W-1:0]   ad_oe_n_o
);

	localparam int CTL_N = `DPHP_C_L1 + 1;

	logic [CTL_N-1:0]              ctl_meta_q;
	logic [CTL_N-1:0]              ctl_q;
	logic [`DPHP_STRAP_W-1:0]      strap_meta_q;
	logic [`DPHP_STRAP_W-1:0]      strap_q;
	logic [`DPHP_ADDR_W-1:0]       addr_meta_q;
	logic [`DPHP_ADDR_W-1:0]       addr_q;
	logic [`DPHP_DATA_W-1:0]       din_meta_q;
	logic [`DPHP_DATA_W-1:0]       din_q;
	logic [1:0]                    settle_q;
	dphp_pkg::dphp_mode_t          mode_q;
	dphp_pkg::dphp_mode_t          strap_mode;
	dphp_pkg::dphp_wstate_t        wstate_q;
	dphp_pkg::dphp_wstate_t        wstate_d;
	logic [1:0]                    lanes_q;
	logic [1:0]                    lanes_d;
	logic [`DPHP_WADDR_W-1:0]      wr_addr_q;
	logic [`DPHP_DATA_W-1:0]       wr_data_q;
	logic                          byte_sel_q;
	logic                          is_8bit;
	logic                          rd_act;
	logic [1:0]                    wr_lanes;
	logic                          commit;
	logic [`DPHP_WADDR_W-1:0]      word_addr;
	logic [`DPHP_DATA_W-1:0]       wr_word;
	logic [`DPHP_DATA_W-1:0]       rdata;
	logic [`DPHP_DATA_W-1:0]       ad_q;
	logic [`DPHP_DATA_W-1:0]       ad_oe_n_q;
	logic                          cs_s;
	logic                          rd_s;
	logic                          wr_s;
	logic                          wrl_s;
	logic                          wrh_s;
	logic                          en_s;
	logic                          rnw_s;
	logic                          l0_s;
	logic                          l1_s;

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ctl_meta_q <= '0;
			ctl_q      <= '0;
		end else begin
			ctl_meta_q <= {lane1_select_i, lane0_select_i, rnw_i, en_i,
				write_high_strobe_i, write_low_strobe_i, wr_i, rd_i,
				cs_i};
			ctl_q      <= ctl_meta_q;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			strap_meta_q <= '0;
			strap_q      <= '0;
		end else begin
			strap_meta_q <= {mode_strap_4_i, mode_strap_3_i,
				mode_strap_2_i};
			strap_q      <= strap_meta_q;
		end
	end

	// address and data are only read once settled under a held strobe
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			addr_meta_q <= '0;
			addr_q      <= '0;
			din_meta_q  <= '0;
			din_q       <= '0;
		end else begin
			addr_meta_q <= addr_i;
			addr_q      <= addr_meta_q;
			din_meta_q  <= ad_i;
			din_q       <= din_meta_q;
		end
	end

	assign cs_s  = ctl_q[`DPHP_C_CS];
	assign rd_s  = ctl_q[`DPHP_C_RD];
	assign wr_s  = ctl_q[`DPHP_C_WR];
	assign wrl_s = ctl_q[`DPHP_C_WRL];
	assign wrh_s = ctl_q[`DPHP_C_WRH];
	assign en_s  = ctl_q[`DPHP_C_EN];
	assign rnw_s = ctl_q[`DPHP_C_RNW];
	assign l0_s  = ctl_q[`DPHP_C_L0];
	assign l1_s  = ctl_q[`DPHP_C_L1];

	// multiplexed strap codes are not served and leave the port idle
	always_comb begin
		case (strap_q)
			3'b000: strap_mode = dphp_pkg::mode_sep8;
			3'b100: strap_mode = dphp_pkg::mode_en8;
			3'b001: strap_mode = dphp_pkg::mode_sep16;
			3'b101: strap_mode = dphp_pkg::mode_sel16;
			default: strap_mode = dphp_pkg::mode_none;
		endcase
	end

	// straps taken once after the sync chain has filled
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			settle_q <= '0;
			mode_q   <= dphp_pkg::mode_none;
		end else if (settle_q != `DPHP_STRAP_SETTLE) begin
			settle_q <= settle_q + 2'h1;
			if (settle_q == `DPHP_STRAP_SETTLE - 2'h1) begin
				mode_q <= strap_mode;
			end
		end
	end

	assign is_8bit = (mode_q == dphp_pkg::mode_sep8) ||
		(mode_q == dphp_pkg::mode_en8);

	// 8-bit modes address bytes, 16-bit modes address words
	always_comb begin
		if (is_8bit) begin
			word_addr = addr_q[`DPHP_ADDR_W-1:1];
		end else begin
			word_addr = addr_q[`DPHP_WADDR_W-1:0];
		end
	end

	// read window; a read overlapping a write strobe is not driven
	always_comb begin
		case (mode_q)
			dphp_pkg::mode_sep8:  rd_act = cs_s && rd_s && !wr_s;
			dphp_pkg::mode_en8:   rd_act = cs_s && en_s && rnw_s;
			dphp_pkg::mode_sep16: rd_act = cs_s && rd_s &&
				!wrl_s && !wrh_s;
			dphp_pkg::mode_sel16: rd_act = cs_s && rnw_s &&
				(l0_s || l1_s);
			default:              rd_act = 1'b0;
		endcase
	end

	// lanes a write strobe currently covers
	always_comb begin
		case (mode_q)
			dphp_pkg::mode_sep8: begin
				wr_lanes = (cs_s && wr_s && !rd_s) ?
					(addr_q[0] ? `DPHP_LANE_HI : `DPHP_LANE_LO) :
					`DPHP_LANE_NONE;
			end
			// direction low with enable is a write
			dphp_pkg::mode_en8: begin
				wr_lanes = (cs_s && en_s && !rnw_s) ?
					(addr_q[0] ? `DPHP_LANE_HI : `DPHP_LANE_LO) :
					`DPHP_LANE_NONE;
			end
			dphp_pkg::mode_sep16: begin
				wr_lanes = (cs_s && !rd_s) ? {wrh_s, wrl_s} :
					`DPHP_LANE_NONE;
			end
			dphp_pkg::mode_sel16: begin
				wr_lanes = (cs_s && !rnw_s) ? {l1_s, l0_s} :
					`DPHP_LANE_NONE;
			end
			default: wr_lanes = `DPHP_LANE_NONE;
		endcase
	end

	// 8-bit data sits on the low pins and is copied to either lane
	always_comb begin
		if (is_8bit) begin
			wr_word = {din_q[7:0], din_q[7:0]};
		end else begin
			wr_word = din_q;
		end
	end

	always_comb begin
		wstate_d = wstate_q;
		lanes_d  = lanes_q;
		commit   = 1'b0;
		case (wstate_q)
			dphp_pkg::wst_idle: begin
				if (wr_lanes != `DPHP_LANE_NONE) begin
					wstate_d = dphp_pkg::wst_pulse;
					lanes_d  = wr_lanes;
				end
			end
			dphp_pkg::wst_pulse: begin
				if (wr_lanes != `DPHP_LANE_NONE) begin
					lanes_d = lanes_q | wr_lanes;
				end else begin
					commit   = 1'b1;
					wstate_d = dphp_pkg::wst_idle;
					lanes_d  = `DPHP_LANE_NONE;
				end
			end
			default: begin
				wstate_d = dphp_pkg::wst_idle;
				lanes_d  = `DPHP_LANE_NONE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			wstate_q <= dphp_pkg::wst_idle;
			lanes_q  <= `DPHP_LANE_NONE;
		end else begin
			wstate_q <= wstate_d;
			lanes_q  <= lanes_d;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			wr_addr_q <= '0;
			wr_data_q <= '0;
		end else if (wr_lanes != `DPHP_LANE_NONE) begin
			wr_addr_q <= word_addr;
			wr_data_q <= wr_word;
		end
	end

	// byte select registered on the same edge as the memory's read, so the two stay aligned
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			byte_sel_q <= 1'b0;
		end else begin
			byte_sel_q <= addr_q[0];
		end
	end

	dphp_mem u_mem (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.we_i       (commit),
		.be_i       (lanes_q),
		.waddr_i    (wr_addr_q),
		.wdata_i    (wr_data_q),
		.raddr_i    (word_addr),
		.rdata_o    (rdata)
	);

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ad_oe_n_q <= `DPHP_OE_OFF;
		end else if (!rd_act) begin
			ad_oe_n_q <= `DPHP_OE_OFF;
		end else if (is_8bit) begin
			// upper pins unused in 8-bit modes
			ad_oe_n_q <= `DPHP_OE_LOW_BYTE;
		end else begin
			ad_oe_n_q <= `DPHP_OE_WORD;
		end
	end

	// data lag the enable by one edge: briefly stale, as on the pins
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ad_q <= `DPHP_DOUT_RST;
		end else if (is_8bit) begin
			ad_q <= {8'h00, byte_sel_q ? rdata[15:8] : rdata[7:0]};
		end else begin
			ad_q <= rdata;
		end
	end

	assign ad_o      = ad_q;
	assign ad_oe_n_o = ad_oe_n_q;

endmodule : dphp_port

// File: bench/dphp_port_assertions.sv
/* pin drive and release timing of the host port, per strap mode
   assumes straps only change while rstn_i is low */
`timescale 1ns/1ps
`include "dphp_regs.svh"
module dphp_port_chk (
	input wire logic        core_clk_i,
	input wire logic        rstn_i,
	input wire logic        mode_strap_2_i,
	input wire logic        mode_strap_3_i,
	input wire logic        mode_strap_4_i,
	input wire logic        cs_i,
	input wire logic        rd_i,
	input wire logic        wr_i,
	input wire logic        write_low_strobe_i,
	input wire logic        write_high_strobe_i,
	input wire logic        en_i,
	input wire logic        rnw_i,
	input wire logic        lane0_select_i,
	input wire logic        lane1_select_i,
	input wire logic [15:0] ad_oe_n_o
);
	wire s2 = mode_strap_2_i;
	wire s4 = mode_strap_4_i;
	wire ok = !mode_strap_3_i;
	wire any_lane = lane0_select_i || lane1_select_i;
	wire any_wlane = write_low_strobe_i || write_high_strobe_i;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	// five cycles cover the two synchroniser flops plus the output register
	sep8_drive_a: assert property (
		ok && !s2 && !s4 && (cs_i && rd_i && !wr_i)[*5]
		|-> ad_oe_n_o == `DPHP_OE_LOW_BYTE)
		else $error("sep8 read not driven");
	sep_off_a: assert property (
		ok && !s4 && (!cs_i || !rd_i)[*5]
		|-> ad_oe_n_o == `DPHP_OE_OFF)
		else $error("strobe mode bus not released");
	en8_drive_a: assert property (
		ok && !s2 && s4 && (cs_i && en_i && rnw_i)[*5]
		|-> ad_oe_n_o == `DPHP_OE_LOW_BYTE)
		else $error("enable read not driven");
	en8_off_a: assert property (
		ok && !s2 && s4 && (!cs_i || !en_i || !rnw_i)[*5]
		|-> ad_oe_n_o == `DPHP_OE_OFF)
		else $error("enable mode bus not released");
	sep16_drive_a: assert property (
		ok && s2 && !s4 && (cs_i && rd_i && !any_wlane)[*5]
		|-> ad_oe_n_o == `DPHP_OE_WORD)
		else $error("word read not driven");
	sel16_drive_a: assert property (
		ok && s2 && s4 && (cs_i && rnw_i && any_lane)[*5]
		|-> ad_oe_n_o == `DPHP_OE_WORD)
		else $error("lane read not driven");
	sel16_off_a: assert property (
		ok && s2 && s4 && (!cs_i || !rnw_i || !any_lane)[*5]
		|-> ad_oe_n_o == `DPHP_OE_OFF)
		else $error("lane mode bus not released");
	upper_off_a: assert property (
		!s2 |-> ad_oe_n_o[15:8] == 8'hFF)
		else $error("upper pins driven in byte mode");
	no_mode_a: assert property (
		!ok |-> ad_oe_n_o == `DPHP_OE_OFF)
		else $error("pins driven without a mode");
endmodule : dphp_port_chk

bind dphp_port dphp_port_chk u_chk (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i),
	.mode_strap_2_i(mode_strap_2_i), .mode_strap_3_i(mode_strap_3_i),
	.mode_strap_4_i(mode_strap_4_i), .cs_i(cs_i), .rd_i(rd_i), .wr_i(wr_i),
	.write_low_strobe_i(write_low_strobe_i),
	.write_high_strobe_i(write_high_strobe_i), .en_i(en_i), .rnw_i(rnw_i),
	.lane0_select_i(lane0_select_i), .lane1_select_i(lane1_select_i),
	.ad_oe_n_o(ad_oe_n_o)
);

// File: bench/dphp_host.sv
/* behavioural host controller for the parallel host port
   assumes the bench calls xfer and that strobes move on falling edges */
`timescale 1ns/1ps
module dphp_host (
	input  wire logic        core_clk_i,
	input  wire logic [15:0] rdata_i,
	input  wire logic [15:0] oe_n_i,
	output logic             cs_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic             lo_strobe_o,
	output logic             hi_strobe_o,
	output logic             en_o,
	output logic             rnw_o,
	output logic             lane0_o,
	output logic             lane1_o,
	output logic      [14:0] addr_o,
	output logic      [15:0] bus_o
);
	logic        drv_q = 0;
	logic        flip_q = 0;
	logic [15:0] dat_q = 16'h0000;
	initial {cs_o, rd_o, wr_o, lo_strobe_o, hi_strobe_o} = '0;
	initial {en_o, rnw_o, lane0_o, lane1_o, addr_o} = '0;
	// undriven wire shows a moving pattern so stale values cannot match
	always @(posedge core_clk_i) flip_q <= ~flip_q;
	assign bus_o = (~oe_n_i & rdata_i)
		| (oe_n_i & (drv_q ? dat_q : ({16{flip_q}} ^ 16'hA5C3)));
	task automatic xfer(input int m, input bit w, input bit [1:0] ln,
		input logic [14:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic [15:0] oe);
		@(negedge core_clk_i);
		cs_o = 1;
		addr_o = a;
		dat_q = d;
		drv_q = w;
		rnw_o = !w;
		repeat (3) @(negedge core_clk_i);
		// one strobe kind, data set first
		case (m)
			0: {rd_o, wr_o} = {!w, w};
			1: en_o = 1;
			2: {rd_o, lo_strobe_o, hi_strobe_o} = {!w, w & ln[0], w & ln[1]};
			default: {lane1_o, lane0_o} = ln;
		endcase
		repeat (6) @(negedge core_clk_i);
		q = bus_o;
		oe = oe_n_i;
		{rd_o, wr_o, lo_strobe_o, hi_strobe_o, en_o, lane0_o, lane1_o} = '0;
		repeat (5) @(negedge core_clk_i);
		cs_o = 0;
		drv_q = 0;
		repeat (2) @(negedge core_clk_i);
	endtask : xfer
endmodule : dphp_host

// File: bench/tb.sv
/* self-checking bench: every strap mode written and read back
   assumes dphp_host drives the pins and the checker is bound */
`timescale 1ns/1ps
`include "dphp_regs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
	logic        core_clk_i = 0, rstn_i = 0;
	logic        mode_strap_2_i = 0, mode_strap_3_i = 0, mode_strap_4_i = 0;
	logic        cs_i, rd_i, wr_i, write_low_strobe_i, write_high_strobe_i;
	logic        en_i, rnw_i, lane0_select_i, lane1_select_i;
	logic [14:0] addr_i;
	logic [15:0] ad_i, ad_o, ad_oe_n_o, q, oe;
	int          n_fail = 0, cmp_count = 0;
	always #10 core_clk_i = ~core_clk_i;
	dphp_port u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.mode_strap_2_i(mode_strap_2_i), .mode_strap_3_i(mode_strap_3_i),
		.mode_strap_4_i(mode_strap_4_i), .cs_i(cs_i), .rd_i(rd_i),
		.wr_i(wr_i), .write_low_strobe_i(write_low_strobe_i),
		.write_high_strobe_i(write_high_strobe_i), .en_i(en_i),
		.rnw_i(rnw_i), .lane0_select_i(lane0_select_i),
		.lane1_select_i(lane1_select_i), .addr_i(addr_i), .ad_i(ad_i),
		.ad_o(ad_o), .ad_oe_n_o(ad_oe_n_o));
	dphp_host u_host (.core_clk_i(core_clk_i), .rdata_i(ad_o),
		.oe_n_i(ad_oe_n_o), .cs_o(cs_i), .rd_o(rd_i), .wr_o(wr_i),
		.lo_strobe_o(write_low_strobe_i), .hi_strobe_o(write_high_strobe_i),
		.en_o(en_i), .rnw_o(rnw_i), .lane0_o(lane0_select_i),
		.lane1_o(lane1_select_i), .addr_o(addr_i), .bus_o(ad_i));
	task automatic set_mode(input logic s2, input logic s3, input logic s4);
		@(negedge core_clk_i);
		rstn_i = 0;
		{mode_strap_2_i, mode_strap_3_i, mode_strap_4_i} = {s2, s3, s4};
		repeat (20) @(negedge core_clk_i);
		`CHK("oe_rst", `DPHP_OE_OFF, ad_oe_n_o)
		`CHK("dout_rst", `DPHP_DOUT_RST, ad_o)
		rstn_i = 1;
		repeat (6) @(negedge core_clk_i);
	endtask : set_mode
	task automatic wr(int m, bit [1:0] ln, logic [14:0] a, logic [15:0] d);
		u_host.xfer(m, 1, ln, a, d, q, oe);
	endtask : wr
	task automatic rd(int m, bit [1:0] ln, logic [14:0] a);
		u_host.xfer(m, 0, ln, a, 16'h0000, q, oe);
	endtask : rd
	task automatic t8(logic s4, int m, logic [14:0] a, logic [7:0] d);
		set_mode(0, 0, s4);
		wr(m, 2'h3, a, {8'hEE, d});
		wr(m, 2'h3, a + 15'h1, {8'hEE, ~d});
		rd(m, 2'h3, a + 15'h1);
		`CHK("b8_hi", ~d, q[7:0])
		`CHK("b8_oe", `DPHP_OE_LOW_BYTE, oe)
		rd(m, 2'h3, a);
		`CHK("b8_lo", d, q[7:0])
		`CHK("b8_off", `DPHP_OE_OFF, ad_oe_n_o)
	endtask : t8
	// word modes, lane writes alter one half
	task automatic t16(logic s4, int m, logic [14:0] b);
		set_mode(1, 0, s4);
		wr(m, 2'h3, b + 15'h1, 16'h5678);
		wr(m, 2'h3, b, 16'h1234);
		wr(m, 2'h1, b, 16'hEEAB);
		wr(m, 2'h2, b, 16'hCDEE);
		rd(m, 2'h2, b);
		`CHK("w16_word", 16'hCDAB, q)
		`CHK("w16_oe", `DPHP_OE_WORD, oe)
		rd(m, 2'h1, b + 15'h1);
		`CHK("w16_next", 16'h5678, q)
		`CHK("w16_off", `DPHP_OE_OFF, ad_oe_n_o)
	endtask : t16
	// strap 3 high keeps pins released
	task automatic t_nomode;
		set_mode(0, 1, 0);
		rd(0, 2'h3, 15'h0004);
		`CHK("none_oe", `DPHP_OE_OFF, oe)
	endtask : t_nomode
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	initial begin
		t8(0, 0, 15'h0004, 8'h5A);
		t8(1, 1, 15'h0006, 8'hC3);
		t16(0, 2, 15'h0009);
		t16(1, 3, 15'h2A50);
		t_nomode;
		final_report;
	end
	// run needs about 500 cycles; twelve times that means a hang
	initial begin
		repeat (6000) @(posedge core_clk_i);
		n_fail++;
		final_report;
	end
endmodule : tb
